/* logic/adc_channel_setup_regs.v */
// wishbone register bank for channel 1..3 and setup 0 configuration
`timescale 1ns/1ns
`include "adc_setup_defines.vh"


module adc_channel_setup_regs #(
	parameter ADDR_W = 8
) (
	input  wire              clk,
	input  wire              rstn,
	input  wire              ce,
	input  wire              wb_cyc_i,
	input  wire              wb_stb_i,
	input  wire              wb_we_i,
	input  wire [ADDR_W-1:0] wb_adr_i,
	input  wire [3:0]        wb_sel_i,
	input  wire [31:0]       wb_dat_i,
	output reg  [31:0]       wb_dat_o,
	output reg               wb_ack_o,
	input  wire              conv_req,
	input  wire [1:0]        conv_channel,
	output reg               conv_valid_ff,
	output reg               conv_enabled_ff,
	output reg  [1:0]        conv_setup_ff,
	output reg  [4:0]        conv_pos_sel_ff,
	output reg  [4:0]        conv_neg_sel_ff,
	output reg               conv_bipolar_ff,
	output reg               conv_rbuf_pos_ff,
	output reg               conv_rbuf_neg_ff,
	output reg               conv_abuf_pos_ff,
	output reg               conv_abuf_neg_ff,
	output reg  [1:0]        conv_ref_sel_ff,
	output reg               conv_bad_ff,
	output reg  [2:0]        channel_enables_ff
);

	localparam NUM_CH = 3;

	// bus decode

	wire                     bus_req;
	wire                     bus_write;
	wire [`IDX_W-1:0]        reg_index;
	wire [1:0]               lane_en;
	wire [15:0]              wdata;
	wire                     adr_in_bank;

	// address bits above the index must be zero, or the bank would repeat in the map
	generate
		if (ADDR_W > `IDX_W + 2) begin : g_adr_hi
			assign adr_in_bank = ~|wb_adr_i[ADDR_W-1:`IDX_W+2];
		end else begin : g_adr_fit
			assign adr_in_bank = 1'b1;
		end
	endgenerate

	assign bus_req   = wb_cyc_i & wb_stb_i;
	assign reg_index = wb_adr_i[`IDX_W+1:2];
	assign lane_en   = wb_sel_i[1:0];
	assign wdata     = wb_dat_i[15:0];

	// write lands on the edge where the master sees ack
	assign bus_write = bus_req & wb_we_i & wb_ack_o & ce;

	// storage

	wire [16*NUM_CH-1:0]     ch_q;
	wire [15:0]              setup_q;
	wire [NUM_CH-1:0]        ch_bad;
	wire [NUM_CH-1:0]        ch_en;
	wire [2*NUM_CH-1:0]      ch_su;
	wire [5*NUM_CH-1:0]      ch_pos;
	wire [5*NUM_CH-1:0]      ch_neg;

	// codes outside the pin and internal ranges are passed on but flagged bad
	function src_ok;
		input [4:0] code;
		begin
			src_ok = (code <= `SRC_PIN_MAX) ||
				((code >= `SRC_INT_MIN) && (code <= `SRC_INT_MAX));
		end
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi = gi + 1) begin : g_ch
			wire        sel_me;
			wire [15:0] q;

			assign sel_me = adr_in_bank & (reg_index == (`IDX_CH1 + gi));

			cfg_reg #(
				.RESET_VAL (`CH_RESET),
				.WMASK     (`CH_WMASK)
			) u_ch (
				.clk   (clk),
				.rstn  (rstn),
				.ce    (ce),
				.wr    (bus_write & sel_me),
				.be    (lane_en),
				.wdata (wdata),
				.q     (q)
			);

			assign ch_q[16*gi +: 16] = q;

			assign ch_en[gi]       = q[`CH_EN_BIT];
			assign ch_su[2*gi +: 2] = q[`CH_SU_HI:`CH_SU_LO];

			assign ch_pos[5*gi +: 5] = q[`CH_POS_HI:`CH_POS_LO];

			assign ch_neg[5*gi +: 5] = q[`CH_NEG_HI:`CH_NEG_LO];

			assign ch_bad[gi] = ~src_ok(q[`CH_POS_HI:`CH_POS_LO]) |
				~src_ok(q[`CH_NEG_HI:`CH_NEG_LO]);
		end
	endgenerate

	wire sel_setup0;

	assign sel_setup0 = adr_in_bank & (reg_index == `IDX_SETUP0);

	cfg_reg #(
		.RESET_VAL (`SETUP_RESET),
		.WMASK     (`SETUP_WMASK)
	) u_setup0 (
		.clk   (clk),
		.rstn  (rstn),
		.ce    (ce),
		.wr    (bus_write & sel_setup0),
		.be    (lane_en),
		.wdata (wdata),
		.q     (setup_q)
	);

	// setup fields

	wire       su_bipolar;
	wire       su_rbuf_pos;
	wire       su_rbuf_neg;
	wire       su_abuf_pos;
	wire       su_abuf_neg;
	wire [1:0] su_ref_sel;
	wire       su_ref_bad;

	assign su_bipolar  = setup_q[`SU_CODING_BIT];

	assign su_rbuf_pos = setup_q[`SU_RBUF_P_BIT];

	assign su_rbuf_neg = setup_q[`SU_RBUF_N_BIT];

	assign su_abuf_pos = setup_q[`SU_ABUF_P_BIT];

	assign su_abuf_neg = setup_q[`SU_ABUF_N_BIT];

	assign su_ref_sel  = setup_q[`SU_REF_HI:`SU_REF_LO];

	assign su_ref_bad  = (su_ref_sel == `REF_UNUSED);

	// status: live view of settings that name no real source

	reg  [15:0] status_ff;
	wire [15:0] nxt_status;

	assign nxt_status = {12'h000, su_ref_bad, ch_bad};

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			status_ff <= 16'h0000;
		end else if (ce) begin
			status_ff <= nxt_status;
		end
	end

	// read mux

	reg [15:0] rd_val;

	always @* begin
		if (!adr_in_bank) begin
			rd_val = 16'h0000;
		end else if (reg_index == `IDX_CH1) begin
			rd_val = ch_q[15:0];
		end else if (reg_index == `IDX_CH2) begin
			rd_val = ch_q[31:16];
		end else if (reg_index == `IDX_CH3) begin
			rd_val = ch_q[47:32];
		end else if (reg_index == `IDX_SETUP0) begin
			rd_val = setup_q;
		end else if (reg_index == `IDX_STATUS) begin
			rd_val = status_ff;
		end else begin
			// unmapped reads answer zero, writes vanish
			rd_val = 16'h0000;
		end
	end

	// classic handshake: ack one cycle after the request, then drop

	wire        nxt_ack;
	wire [31:0] nxt_dat;

	// with ce low the ack freezes too, so a master must stall along with the bank
	assign nxt_ack = bus_req & ~wb_ack_o;
	assign nxt_dat = nxt_ack ? {16'h0000, rd_val} : wb_dat_o;

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else if (ce) begin
			wb_ack_o <= nxt_ack;
			wb_dat_o <= nxt_dat;
		end
	end

	// conversion side: pick the channel and its setup

	reg        pick_en;
	reg  [1:0] pick_su;
	reg  [4:0] pick_pos;
	reg  [4:0] pick_neg;
	reg        pick_bad;
	reg        pick_valid;

	always @* begin
		pick_en    = 1'b0;
		pick_su    = `SETUP_ZERO;
		pick_pos   = 5'h00;
		pick_neg   = 5'h00;
		pick_bad   = 1'b0;
		pick_valid = 1'b1;
		case (conv_channel)
			2'h1: begin
				pick_en  = ch_en[0];
				pick_su  = ch_su[1:0];
				pick_pos = ch_pos[4:0];
				pick_neg = ch_neg[4:0];
				pick_bad = ch_bad[0];
			end
			2'h2: begin
				pick_en  = ch_en[1];
				pick_su  = ch_su[3:2];
				pick_pos = ch_pos[9:5];
				pick_neg = ch_neg[9:5];
				pick_bad = ch_bad[1];
			end
			2'h3: begin
				pick_en  = ch_en[2];
				pick_su  = ch_su[5:4];
				pick_pos = ch_pos[14:10];
				pick_neg = ch_neg[14:10];
				pick_bad = ch_bad[2];
			end
			default: begin
				// channel zero lives outside this bank
				pick_valid = 1'b0;
			end
		endcase
	end

	wire su_missing;

	// only setup zero is held here; other selections fall back to it
	assign su_missing = (pick_su != `SETUP_ZERO);

	wire pick_fault;

	// any setting the converter cannot honour marks the request
	assign pick_fault = ~pick_valid | pick_bad | su_ref_bad | su_missing;

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			conv_valid_ff    <= 1'b0;
			conv_enabled_ff  <= 1'b0;
			conv_setup_ff    <= 2'h0;
			conv_pos_sel_ff  <= 5'h00;
			conv_neg_sel_ff  <= 5'h00;
			conv_bipolar_ff  <= 1'b0;
			conv_rbuf_pos_ff <= 1'b0;
			conv_rbuf_neg_ff <= 1'b0;
			conv_abuf_pos_ff <= 1'b0;
			conv_abuf_neg_ff <= 1'b0;
			conv_ref_sel_ff  <= 2'h0;
			conv_bad_ff      <= 1'b0;
		end else if (ce) begin
			conv_valid_ff <= conv_req;
			if (conv_req) begin
				conv_enabled_ff <= pick_en & pick_valid;
				conv_setup_ff   <= pick_su;
				conv_pos_sel_ff <= pick_pos;
				conv_neg_sel_ff <= pick_neg;
				conv_bipolar_ff  <= su_bipolar;
				conv_rbuf_pos_ff <= su_rbuf_pos;
				conv_rbuf_neg_ff <= su_rbuf_neg;
				conv_abuf_pos_ff <= su_abuf_pos;
				conv_abuf_neg_ff <= su_abuf_neg;
				conv_ref_sel_ff  <= su_ref_sel;
				conv_bad_ff      <= pick_fault;
			end
		end
	end

	// enable bits mirrored for the sequencer

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			channel_enables_ff <= 3'h0;
		end else if (ce) begin
			channel_enables_ff <= ch_en;
		end
	end

endmodule // adc_channel_setup_regs

/* logic/adc_setup_defines.vh */
// register indices, field positions, reset values and codes of the setup bank
`ifndef ADC_SETUP_DEFINES_VH
`define ADC_SETUP_DEFINES_VH

`define IDX_CH1          6'h11
`define IDX_CH2          6'h12
`define IDX_CH3          6'h13
`define IDX_SETUP0       6'h20
`define IDX_STATUS       6'h30
`define IDX_W            6

`define CH_RESET         16'h0001
`define CH_WMASK         16'hB3FF
`define SETUP_RESET      16'h1320
`define SETUP_WMASK      16'h1F30

`define CH_EN_BIT        15
`define CH_SU_HI         13
`define CH_SU_LO         12
`define CH_POS_HI        9
`define CH_POS_LO        5
`define CH_NEG_HI        4
`define CH_NEG_LO        0

`define SU_CODING_BIT    12
`define SU_RBUF_P_BIT    11
`define SU_RBUF_N_BIT    10
`define SU_ABUF_P_BIT    9
`define SU_ABUF_N_BIT    8
`define SU_REF_HI        5
`define SU_REF_LO        4

`define SRC_PIN_MAX      5'h04
`define SRC_INT_MIN      5'h11
`define SRC_INT_MAX      5'h16
`define REF_UNUSED       2'h1
`define SETUP_ZERO       2'h0

`endif

/* logic/cfg_reg.v */
// one 16-bit configuration register with byte lanes and a write mask
`timescale 1ns/1ns

module cfg_reg #(
	parameter [15:0] RESET_VAL = 16'h0000,
	parameter [15:0] WMASK     = 16'hFFFF
) (
	input  wire        clk,
	input  wire        rstn,
	input  wire        ce,
	input  wire        wr,
	input  wire [1:0]  be,
	input  wire [15:0] wdata,
	output reg  [15:0] q
);

	wire [15:0] lane_mask;

	// read-only and reserved bits never take written data
	assign lane_mask = WMASK & {{8{be[1]}}, {8{be[0]}}};

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q <= RESET_VAL;
		end else if (ce && wr) begin
			q <= (q & ~lane_mask) | (wdata & lane_mask);
		end
	end

endmodule // cfg_reg

/* tb/adc_channel_setup_regs_asserts.sv */
// port checks on the setup register bank
`timescale 1ns/1ns
module adc_channel_setup_regs_chk #(
	parameter ADDR_W = 8
) (
	input wire              clk,
	input wire              rstn,
	input wire              ce,
	input wire              wb_cyc_i,
	input wire              wb_stb_i,
	input wire              wb_we_i,
	input wire [ADDR_W-1:0] wb_adr_i,
	input wire [31:0]       wb_dat_o,
	input wire              wb_ack_o,
	input wire              conv_req,
	input wire [1:0]        conv_channel,
	input wire              conv_valid_ff,
	input wire              conv_bad_ff
);
	wire [5:0] idx = wb_adr_i[7:2];
	wire       rd  = wb_ack_o && !wb_we_i;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	a_ack_timing: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
		else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o && ce |=> !wb_ack_o)
		else $error("ack too long");
	a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
		else $error("upper data set");
	a_setup_rsvd: assert property (rd && idx == 6'h20 |-> (wb_dat_o & 32'h0000E0CF) == 0)
		else $error("setup reserved set");
	a_ch_rsvd: assert property (rd && idx inside {6'h11, 6'h12, 6'h13}
		|-> (wb_dat_o & 32'h00004C00) == 0)
		else $error("channel reserved set");
	a_rd_unmapped: assert property (rd && !(idx inside {6'h11, 6'h12, 6'h13, 6'h20, 6'h30})
		|-> wb_dat_o == 32'h0)
		else $error("unmapped data");
	a_valid_pulse: assert property (conv_req && ce |=> conv_valid_ff)
		else $error("valid missing");
	a_valid_only: assert property (!conv_req && ce |=> !conv_valid_ff)
		else $error("valid stray");
	a_bad_ch0: assert property (conv_req && ce && conv_channel == 2'h0 |=> conv_bad_ff)
		else $error("channel 0 not flagged");
	c_write: cover property (wb_ack_o && wb_we_i);
	c_unmapped: cover property (rd && idx == 6'h3C);
	c_conv_bad: cover property (conv_valid_ff && conv_bad_ff);
endmodule // adc_channel_setup_regs_chk

/* tb/test_adc_channel_setup_regs.sv */
// self-checking bench for the setup register bank
`timescale 1ns/1ns
module test_adc_channel_setup_regs;
	logic        clk, rstn, ce, cyc, stb, we, req;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat, q;
	logic [1:0]  chn;
	logic [41:0] rows [6];
	wire         ack, valid, en, bip, rp, rn, ap, an, bad;
	wire  [1:0]  su, ref_sel;
	wire  [4:0]  pos, neg;
	wire  [2:0]  ens;
	wire  [20:0] fld = {en, su, pos, neg, bip, rp, rn, ap, an, ref_sel, bad};
	int          fails, comparisons, i;

	adc_channel_setup_regs u_dut (.clk(clk), .rstn(rstn), .ce(ce), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .conv_req(req), .conv_channel(chn),
		.conv_valid_ff(valid), .conv_enabled_ff(en), .conv_setup_ff(su),
		.conv_pos_sel_ff(pos), .conv_neg_sel_ff(neg), .conv_bipolar_ff(bip),
		.conv_rbuf_pos_ff(rp), .conv_rbuf_neg_ff(rn), .conv_abuf_pos_ff(ap),
		.conv_abuf_neg_ff(an), .conv_ref_sel_ff(ref_sel), .conv_bad_ff(bad),
		.channel_enables_ff(ens));

	always #5 clk = ~clk;

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask

	task bus(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [1:0] s);
		int n;
		n = 0;
		@(posedge clk);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= {16'h0000, d};
		sel  <= {2'h0, s};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) fails++;
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task conv(input logic [1:0] c);
		@(posedge clk);
		req <= 1'b1;
		chn <= c;
		@(posedge clk);
		req <= 1'b0;
		@(posedge clk);
		chk("valid", 1, valid);
	endtask

	task wrap_up;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		#100000;
		fails++;
		wrap_up();
	end

	initial begin
		rows[0] = {8'h44, 16'hFFFF, 2'h3, 16'hB3FF};
		rows[1] = {8'h48, 16'h0000, 2'h3, 16'h0000};
		rows[2] = {8'h4C, 16'h8083, 2'h3, 16'h8083};
		rows[3] = {8'h80, 16'h1FFF, 2'h3, 16'h1F30};
		rows[4] = {8'h80, 16'h0000, 2'h3, 16'h0000};
		rows[5] = {8'hF0, 16'hFFFF, 2'h3, 16'h0000};
		{clk, rstn, cyc, stb, we, req, ce} = 7'h01;
		{adr, sel, wdat, chn} = 0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		for (i = 0; i < 6; i++) begin
			bus(1, rows[i][41:34], rows[i][33:18], rows[i][17:16]);
			bus(0, rows[i][41:34], 0, 3);
			chk("readback", {16'h0, rows[i][15:0]}, q);
			$display("row %0d done", i);
		end
		// low byte lane only
		bus(1, 8'h80, 16'h1FFF, 1);
		bus(0, 8'h80, 0, 3);
		chk("lane", 32'h0030, q);
		$display("lane test done");
		conv(3);
		chk("conv3", {1'b1, 2'h0, 5'h04, 5'h03, 1'b0, 4'h0, 2'h3, 1'b0}, fld);
		chk("enables", 3'h5, ens);
		conv(1);
		chk("conv1", {1'b1, 2'h3, 5'h1F, 5'h1F, 1'b0, 4'h0, 2'h3, 1'b1}, fld);
		conv(0);
		chk("bad ch0", 1, bad);
		bus(1, 8'h80, 16'h1C00, 3);
		conv(2);
		chk("conv2", {1'b0, 2'h0, 5'h00, 5'h00, 1'b1, 4'hC, 2'h0, 1'b0}, fld);
		// ce low: a request must leave valid and the conversion outputs as they were
		@(posedge clk);
		ce  <= 1'b0;
		req <= 1'b1;
		chn <= 2'h3;
		repeat (2) @(posedge clk);
		chk("frozen valid", 0, valid);
		chk("frozen conv", {1'b0, 2'h0, 5'h00, 5'h00, 1'b1, 4'hC, 2'h0, 1'b0}, fld);
		ce  <= 1'b1;
		req <= 1'b0;
		$display("conversion test done");
		@(posedge clk);
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		for (i = 0; i < 3; i++) begin
			bus(0, 8'h44 + 8'(4 * i), 0, 3);
			chk("ch reset", 32'h0001, q);
		end
		bus(0, 8'h80, 0, 3);
		chk("setup reset", 32'h1320, q);
		conv(1);
		chk("conv rst", {1'b0, 2'h0, 5'h00, 5'h01, 1'b1, 4'h3, 2'h2, 1'b0}, fld);
		$display("reset test done");
		wrap_up();
	end
endmodule // test_adc_channel_setup_regs

bind adc_channel_setup_regs adc_channel_setup_regs_chk #(.ADDR_W(ADDR_W)) u_chk (.clk(clk),
	.rstn(rstn), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv_req(conv_req),
	.conv_channel(conv_channel), .conv_valid_ff(conv_valid_ff), .conv_bad_ff(conv_bad_ff));
